/* File: hw/amd_pkg.sv */
package amd_pkg;
   localparam int ADDR_W = 20;
   localparam int IDX_W = 16;
   localparam logic [3:0] REG_PC = 4'h0;
   localparam logic [3:0] REG_SP = 4'h1;
   localparam logic [19:0] ADDR_OP_BYTES = 20'h0_0004;
   localparam logic [19:0] ADDR_OP_SEEN = 20'h0_0002;
   localparam logic [19:0] WIDE_PUSH_DEC = 20'h0_0004;
   localparam logic [19:0] WORD_PUSH_DEC = 20'h0_0002;
   localparam logic [19:0] CALL_RET_SKEW = 20'h0_0002;

   typedef enum logic [3:0] {
      OP_OTHER = 4'h0,
      OP_NOP = 4'h1,
      OP_MOVE = 4'h2,
      OP_TWO_OP = 4'h3,
      OP_ADDRESS_ADD = 4'h4,
      OP_ADDRESS_SUBTRACT = 4'h5,
      OP_ADDRESS_COMPARE = 4'h6,
      OP_PUSH = 4'h7,
      OP_EXTENDED_PUSH = 4'h8,
      OP_WIDE_PUSH = 4'h9,
      OP_WIDE_CALL = 4'ha,
      OP_WIDE_MOVE = 4'hb
   } amd_op_t;

   typedef enum logic [2:0] {
      AM_REG = 3'h0,
      AM_INDEXED = 3'h1,
      AM_SYMBOLIC = 3'h2,
      AM_ABSOLUTE = 3'h3,
      AM_INDIRECT = 3'h4,
      AM_INDIR_INC = 3'h5,
      AM_IMMEDIATE = 3'h6
   } amd_mode_t;

   typedef struct packed {
      logic valid;
      amd_op_t op;
      amd_mode_t src_mode;
      amd_mode_t dst_mode;
      logic [3:0] src_reg;
      logic [3:0] dst_reg;
      logic ext;
      logic wide;
      logic enters_lp;
      logic handler_first;
      logic [2:0] bytes;
      logic [ADDR_W-1:0] pc;
      logic [ADDR_W-1:0] sp;
      logic [ADDR_W-1:0] sp_word;
      logic [ADDR_W-1:0] dst_val;
      logic [ADDR_W-1:0] operand;
   } amd_instr_t;

   typedef struct packed {
      logic valid;
      amd_op_t op;
      amd_mode_t src_mode;
      amd_mode_t dst_mode;
      logic ext;
   } amd_prev_t;

   typedef struct packed {
      logic ext_wb;
      logic handler_width;
      logic pc_offset;
      logic sp_load;
      logic ret_skew;
      logic index_unext;
   } amd_flags_t;

   typedef struct packed {
      logic valid;
      logic wide_exec;
      logic [ADDR_W-1:0] pc_next;
      logic [ADDR_W-1:0] sp_next;
      logic [ADDR_W-1:0] alu;
      logic [ADDR_W-1:0] push_val;
      logic push_en;
      logic [ADDR_W-1:0] eff_addr;
      amd_flags_t flags;
   } amd_res_t;

   localparam amd_prev_t PREV_RST = '0;
   localparam amd_res_t RES_RST = '0;
endpackage

/* File: hw/amd_prev.sv */
`timescale 1ns/1ns
`default_nettype none
module amd_prev (
   input wire logic clk,
   input wire logic nrst,
   input wire amd_pkg::amd_instr_t instr,
   output amd_pkg::amd_prev_t prev
);
   import amd_pkg::*;

   typedef struct packed {
      amd_prev_t last;
   } amd_prev_state_t;

   amd_prev_state_t state_r;
   amd_prev_state_t state_nxt;

   // Holds only the previous issued instruction; idle cycles keep it
   always_comb begin
      state_nxt = state_r;
      if (instr.valid) begin
         state_nxt.last.valid = 1'b1;
         state_nxt.last.op = instr.op;
         state_nxt.last.src_mode = instr.src_mode;
         state_nxt.last.dst_mode = instr.dst_mode;
         state_nxt.last.ext = instr.ext;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= '{last: PREV_RST};
      end else begin
         state_r <= state_nxt;
      end
   end

   assign prev = state_r.last;
endmodule
`default_nettype wire

/* File: hw/amd_core.sv */
`timescale 1ns/1ns
`default_nettype none
module amd_core (
   input wire logic clk,
   input wire logic nrst,
   input wire amd_pkg::amd_instr_t instr,
   input wire logic nmi_pending,
   output amd_pkg::amd_res_t result
);
   import amd_pkg::*;

   typedef struct packed {
      amd_res_t res;
      logic lp_armed;
      logic width_poison;
   } amd_state_t;

   amd_state_t state_r;
   amd_state_t state_nxt;
   amd_prev_t prev;

   amd_prev u_prev (
      .clk(clk),
      .nrst(nrst),
      .instr(instr),
      .prev(prev)
   );

   logic [ADDR_W-1:0] seq_pc;
   logic [ADDR_W-1:0] pc_seen;
   logic [ADDR_W-1:0] idx_val;
   logic [ADDR_W-1:0] base_val;
   logic prev_wb;
   logic cur_pc_wr;
   logic prev_mem_push;
   logic sp_idx_call;

   always_comb begin
      seq_pc = instr.pc + ADDR_W'(instr.bytes);
      // Previous op: extended reg source, memory write-back
      prev_wb = prev.valid && prev.ext && prev.op == OP_TWO_OP
         && prev.src_mode == AM_REG
         && (prev.dst_mode == AM_INDEXED || prev.dst_mode == AM_ABSOLUTE
         || prev.dst_mode == AM_SYMBOLIC);
      cur_pc_wr = instr.ext && instr.op == OP_TWO_OP && instr.dst_reg == REG_PC
         && (instr.src_mode == AM_INDIRECT || instr.src_mode == AM_INDIR_INC
         || instr.src_mode == AM_INDEXED);
      prev_mem_push = prev.valid
         && (prev.op == OP_PUSH || prev.op == OP_EXTENDED_PUSH || prev.op == OP_WIDE_PUSH)
         && prev.src_mode != AM_REG && prev.src_mode != AM_IMMEDIATE;
      sp_idx_call = instr.op == OP_WIDE_CALL && instr.src_mode == AM_INDEXED
         && instr.src_reg == REG_SP;
      base_val = (instr.src_reg == REG_SP) ? instr.sp : instr.dst_val;
      if (prev_mem_push && sp_idx_call) begin
         idx_val = {{(ADDR_W-IDX_W){1'b0}}, instr.operand[IDX_W-1:0]};
      end else begin
         idx_val = {{(ADDR_W-IDX_W){instr.operand[IDX_W-1]}}, instr.operand[IDX_W-1:0]};
      end
      // Immediate to PC counts only half the opcode
      if (instr.src_mode == AM_IMMEDIATE && instr.dst_reg == REG_PC) begin
         pc_seen = instr.pc + ADDR_OP_SEEN;
      end else begin
         pc_seen = instr.pc + ADDR_OP_BYTES;
      end
   end

   always_comb begin
      state_nxt = state_r;
      state_nxt.res.valid = instr.valid;
      state_nxt.res.flags = '0;
      state_nxt.res.push_en = 1'b0;
      if (instr.valid) begin
         state_nxt.res.pc_next = seq_pc;
         state_nxt.res.sp_next = instr.sp;
         state_nxt.res.alu = '0;
         state_nxt.res.push_val = '0;
         state_nxt.res.eff_addr = '0;
         state_nxt.res.wide_exec = instr.wide;
         // Low-power width hazard is a two-step arm; any other op clears lp_armed, but width_poison holds until handler_first
         state_nxt.lp_armed = 1'b0;
         if (state_r.width_poison && instr.handler_first) begin
            state_nxt.res.wide_exec = 1'b1;
            state_nxt.res.flags.handler_width = 1'b1;
            state_nxt.width_poison = 1'b0;
         end
         if (state_r.lp_armed && instr.wide && instr.src_mode == AM_REG
               && instr.dst_mode == AM_REG) begin
            state_nxt.width_poison = 1'b1;
         end
         if (instr.enters_lp && instr.src_mode == AM_INDEXED && nmi_pending) begin
            state_nxt.lp_armed = 1'b1;
         end
         case (instr.op)
            OP_TWO_OP: begin
               state_nxt.res.alu = instr.operand;
               if (instr.dst_reg == REG_PC) begin
                  if (prev_wb && cur_pc_wr) begin
                     // PC write dropped; flow falls through
                     state_nxt.res.flags.ext_wb = 1'b1;
                  end else begin
                     state_nxt.res.pc_next = instr.operand;
                  end
               end
            end
            OP_MOVE, OP_WIDE_MOVE: begin
               state_nxt.res.alu = instr.operand;
               if (instr.dst_reg == REG_PC) begin
                  state_nxt.res.pc_next = instr.operand;
               end
            end
            OP_ADDRESS_ADD, OP_ADDRESS_SUBTRACT, OP_ADDRESS_COMPARE: begin
               if (instr.dst_reg == REG_PC) begin
                  state_nxt.res.flags.pc_offset = (instr.src_mode == AM_IMMEDIATE);
                  if (instr.op == OP_ADDRESS_ADD) begin
                     state_nxt.res.alu = pc_seen + instr.operand;
                  end else begin
                     state_nxt.res.alu = pc_seen - instr.operand;
                  end
                  // Compare only sets alu and flags, PC stays sequential
                  if (instr.op != OP_ADDRESS_COMPARE) begin
                     state_nxt.res.pc_next = state_nxt.res.alu;
                  end
               end else if (instr.op == OP_ADDRESS_ADD) begin
                  state_nxt.res.alu = instr.dst_val + instr.operand;
               end else begin
                  state_nxt.res.alu = instr.dst_val - instr.operand;
               end
            end
            OP_PUSH: begin
               state_nxt.res.sp_next = instr.sp - WORD_PUSH_DEC;
               state_nxt.res.push_val = instr.operand;
               state_nxt.res.push_en = 1'b1;
            end
            OP_EXTENDED_PUSH: begin
               state_nxt.res.sp_next = instr.sp - (instr.wide ? WIDE_PUSH_DEC : WORD_PUSH_DEC);
               state_nxt.res.push_val = instr.operand;
               state_nxt.res.push_en = 1'b1;
            end
            OP_WIDE_PUSH: begin
               state_nxt.res.push_val = instr.operand;
               state_nxt.res.push_en = 1'b1;
               if (instr.src_mode == AM_INDIR_INC && instr.src_reg == REG_SP) begin
                  state_nxt.res.sp_next = instr.sp_word;
                  state_nxt.res.flags.sp_load = 1'b1;
               end else begin
                  state_nxt.res.sp_next = instr.sp - WIDE_PUSH_DEC;
               end
            end
            OP_WIDE_CALL: begin
               state_nxt.res.sp_next = instr.sp - WIDE_PUSH_DEC;
               state_nxt.res.push_en = 1'b1;
               state_nxt.res.push_val = seq_pc;
               if (instr.src_mode == AM_REG && instr.src_reg == REG_PC) begin
                  state_nxt.res.push_val = seq_pc - CALL_RET_SKEW;
                  state_nxt.res.flags.ret_skew = 1'b1;
                  state_nxt.res.pc_next = seq_pc;
               end else if (instr.src_mode == AM_INDEXED) begin
                  // Target address is base plus index as the core forms it
                  state_nxt.res.eff_addr = base_val + idx_val;
                  state_nxt.res.pc_next = base_val + idx_val;
                  state_nxt.res.flags.index_unext = prev_mem_push && sp_idx_call
                     && instr.operand[IDX_W-1];
               end else begin
                  state_nxt.res.pc_next = instr.operand;
               end
            end
            OP_NOP, OP_OTHER: begin
               state_nxt.res.alu = '0;
            end
            default: begin
               state_nxt.res.alu = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= '{res: RES_RST, lp_armed: 1'b0, width_poison: 1'b0};
      end else begin
         state_r <= state_nxt;
      end
   end

   assign result = state_r.res;
endmodule
`default_nettype wire

/* File: sim/amd_pmem.sv */
`timescale 1ns/1ns
`default_nettype none
// Fetch stage of program memory: one word a cycle, one cycle late
module amd_pmem (
   input wire logic clk,
   input wire logic nrst,
   input wire amd_pkg::amd_instr_t word,
   output amd_pkg::amd_instr_t instr
);
   import amd_pkg::*;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         instr <= '0;
      end else if (word.valid) begin
         instr <= word;
      end else begin
         // Idle bus must not look like a held word
         instr <= {1'b0, ~instr[$bits(amd_instr_t)-2:0]};
      end
   end
endmodule
`default_nettype wire

/* File: sim/amd_core_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module amd_core_properties (
   input wire logic clk,
   input wire logic nrst,
   input wire amd_pkg::amd_instr_t instr,
   input wire logic nmi_pending,
   input wire amd_pkg::amd_res_t result
);
   import amd_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [19:0] idx_sx;
   assign idx_sx = {{4{instr.operand[15]}}, instr.operand[15:0]};
   sequence s_arm;
      instr.valid && instr.enters_lp && instr.src_mode == AM_INDEXED && nmi_pending;
   endsequence
   sequence s_poison;
      instr.valid && instr.wide && instr.src_mode == AM_REG && instr.dst_mode == AM_REG;
   endsequence
   sequence s_handler;
      instr.valid && instr.handler_first;
   endsequence
   a_answer_next: assert property (instr.valid |=> result.valid)
      else $error("result missing");
   a_idle_quiet: assert property (!instr.valid |=> !result.valid && !result.push_en
      && result.flags == '0) else $error("idle output");
   a_handler_wide: assert property (s_arm ##1 s_poison ##1 s_handler |=>
      result.wide_exec && result.flags.handler_width) else $error("handler width");
   a_addr_offset: assert property (instr.valid && instr.op == OP_ADDRESS_ADD
      && instr.src_mode == AM_IMMEDIATE && instr.dst_reg == REG_PC |=> result.pc_next ==
      $past(instr.pc) + ADDR_OP_SEEN + $past(instr.operand)) else $error("addr pc");
   a_move_exact: assert property (instr.valid && instr.op == OP_MOVE
      && instr.dst_reg == REG_PC |=> result.pc_next == $past(instr.operand)
      && !result.flags.pc_offset) else $error("move pc");
   a_push_load: assert property (instr.valid && instr.op == OP_WIDE_PUSH
      && instr.src_mode == AM_INDIR_INC && instr.src_reg == REG_SP |=>
      result.sp_next == $past(instr.sp_word) && result.flags.sp_load) else $error("sp load");
   a_call_skew: assert property (instr.valid && instr.op == OP_WIDE_CALL
      && instr.src_mode == AM_REG && instr.src_reg == REG_PC |=> result.push_val ==
      $past(instr.pc) + $past(instr.bytes) - CALL_RET_SKEW) else $error("call return");
   a_unext_cause: assert property (result.flags.index_unext |->
      $past(instr.operand[15]) && $past(instr.src_reg) == REG_SP) else $error("index flag");
   a_base_other: assert property (instr.valid && instr.op == OP_WIDE_CALL
      && instr.src_mode == AM_INDEXED && instr.src_reg != REG_SP |=> result.eff_addr ==
      $past(instr.dst_val) + $past(idx_sx)) else $error("call target");
endmodule
`default_nettype wire

/* File: sim/amd_core_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
$display("Error %0t: got %h exp %h", $time, (g), (e)); end end
module amd_core_tb;
   import amd_pkg::*;
   localparam amd_mode_t PM [8] = '{AM_INDIRECT, AM_ABSOLUTE, AM_SYMBOLIC, AM_INDEXED,
      AM_INDIR_INC, AM_REG, AM_IMMEDIATE, AM_INDEXED};
   logic clk = 0;
   logic nrst = 0;
   logic nmi = 0;
   amd_instr_t word = '0;
   amd_instr_t instr;
   amd_res_t res;
   int errors = 0;
   int cmp_count = 0;
   always #2 clk = ~clk;
   amd_pmem u_amd_pmem (.clk(clk), .nrst(nrst), .word(word), .instr(instr));
   amd_core u_amd_core (.clk(clk), .nrst(nrst), .instr(instr), .nmi_pending(nmi),
      .result(res));
   function automatic amd_instr_t mk(amd_op_t op, amd_mode_t sm, logic [3:0] sr,
      logic [3:0] dr);
      amd_instr_t i;
      i = '0;
      i.valid = 1'b1;
      i.op = op;
      i.src_mode = sm;
      i.src_reg = sr;
      i.dst_reg = dr;
      i.bytes = 3'h4;
      i.pc = 20'h0_0100;
      i.sp = 20'h0_2000;
      i.sp_word = 20'h0_1234;
      i.dst_val = 20'h0_0300;
      i.operand = 20'h0_fff0;
      return i;
   endfunction
   task put(input amd_instr_t i);
      @(posedge clk);
      #1;
      word = i;
   endtask
   // Fixed wait: fetch stage plus the one-cycle answer
   task run(input amd_instr_t i);
      put(i);
      @(posedge clk);
      #1;
      word.valid = 1'b0;
      @(posedge clk);
      #1;
      `CHK(res.valid, 1'b1);
   endtask
   task s_addr;
      amd_instr_t a;
      logic [19:0] e;
      for (int k = 0; k < 3; k++) begin
         a = mk(amd_op_t'(OP_ADDRESS_ADD + k), AM_IMMEDIATE, 4'h0, REG_PC);
         e = (k == 2) ? a.pc + 20'h0_0004 : (k == 0) ? a.pc + 20'h0_0002 + a.operand
            : a.pc + 20'h0_0002 - a.operand;
         run(a);
         `CHK(res.pc_next, e);
         `CHK(res.flags.pc_offset, 1'b1);
      end
      // Software compensation: immediate raised by two lands on pc+4+0x10
      a = mk(OP_ADDRESS_ADD, AM_IMMEDIATE, 4'h0, REG_PC);
      a.operand = 20'h0_0012;
      run(a);
      `CHK(res.pc_next, a.pc + 20'h0_0014);
      a = mk(OP_ADDRESS_ADD, AM_IMMEDIATE, 4'h0, REG_SP);
      run(a);
      `CHK(res.alu, a.dst_val + a.operand);
      a = mk(OP_MOVE, AM_IMMEDIATE, 4'h0, REG_PC);
      run(a);
      `CHK(res.pc_next, a.operand);
      `CHK(res.flags.pc_offset, 1'b0);
   endtask
   task s_stack;
      amd_instr_t a;
      a = mk(OP_WIDE_PUSH, AM_INDIR_INC, REG_SP, 4'h0);
      run(a);
      `CHK(res.sp_next, a.sp_word);
      `CHK(res.flags.sp_load, 1'b1);
      `CHK(res.push_en, 1'b1);
      a.src_reg = 4'h5;
      run(a);
      `CHK(res.sp_next, a.sp - 20'h0_0004);
      `CHK(res.flags.sp_load, 1'b0);
      a = mk(OP_WIDE_CALL, AM_REG, REG_PC, 4'h0);
      run(a);
      `CHK(res.push_val, a.pc + 20'h0_0002);
      `CHK(res.flags.ret_skew, 1'b1);
      `CHK(res.pc_next, a.pc + 20'h0_0004);
      `CHK(res.sp_next, a.sp - 20'h0_0004);
      a.src_reg = 4'h5;
      run(a);
      `CHK(res.push_val, a.pc + 20'h0_0004);
      `CHK(res.flags.ret_skew, 1'b0);
   endtask
   task s_idx;
      amd_instr_t p, c;
      logic [19:0] e;
      for (int k = 0; k < 8; k++) begin
         p = mk(k[0] ? OP_EXTENDED_PUSH : OP_PUSH, PM[k], 4'h5, 4'h0);
         c = mk(OP_WIDE_CALL, AM_INDEXED, (k == 7) ? 4'h5 : REG_SP, 4'h0);
         e = ((k == 7) ? c.dst_val : c.sp) + ((k < 5) ? 20'h0_fff0 : 20'hf_fff0);
         put(p);
         if (k == 0) put('0);
         run(c);
         `CHK(res.eff_addr, e);
         `CHK(res.pc_next, e);
         `CHK(res.flags.index_unext, k < 5);
      end
   endtask
   task s_wb;
      amd_instr_t a, b;
      a = mk(OP_TWO_OP, AM_REG, 4'h6, 4'h7);
      a.dst_mode = AM_ABSOLUTE;
      a.ext = 1'b1;
      b = mk(OP_TWO_OP, AM_INDIR_INC, 4'h4, REG_PC);
      b.ext = 1'b1;
      put(a);
      run(b);
      `CHK(res.pc_next, b.pc + 20'h0_0004);
      `CHK(res.flags.ext_wb, 1'b1);
      put(a);
      put(mk(OP_NOP, AM_REG, 4'h0, 4'h0));
      run(b);
      `CHK(res.pc_next, b.operand);
      `CHK(res.flags.ext_wb, 1'b0);
   endtask
   task s_lp;
      amd_instr_t a, b, h;
      nmi = 1'b1;
      a = mk(OP_OTHER, AM_INDEXED, 4'h5, 4'h2);
      a.enters_lp = 1'b1;
      b = mk(OP_WIDE_MOVE, AM_REG, 4'h5, 4'h6);
      b.wide = 1'b1;
      h = mk(OP_MOVE, AM_INDEXED, 4'h5, 4'h6);
      h.handler_first = 1'b1;
      for (int k = 0; k < 2; k++) begin
         put(a);
         if (k == 1) put(mk(OP_NOP, AM_REG, 4'h0, 4'h0));
         put(b);
         run(h);
         `CHK(res.wide_exec, k == 0);
         `CHK(res.flags.handler_width, k == 0);
      end
      nmi = 1'b0;
   endtask
   task end_sim;
      if (errors == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1;
      `CHK(res, RES_RST);
      nrst = 1'b1;
      s_addr;
      s_stack;
      s_idx;
      s_wb;
      s_lp;
      end_sim;
   end
endmodule
bind amd_core amd_core_properties u_amd_core_properties (.clk(clk), .nrst(nrst),
   .instr(instr), .nmi_pending(nmi_pending), .result(result));
`default_nettype wire
